// [common/pmcrb_map.svh]
// register offsets, field positions and reset values of the configuration register bank
// assumes a host-side decoder that hands over a 9-bit register address and 8-bit data
// Function
// - reg four second voltage code clamps to 0x02..0x38, 50 mV steps
// - sleep bit forces reg four sleep while second setting selected
// - backup charge current code decoded to microamp steps, zero disables
// - backup termination code decoded to ascending voltages, zero disables
// - slave address is the base field times eight
// - device also answers at base times eight plus one
// - address base writable only while application fuse lock is low
// - bit 6 of pin config keeps interface permanently high speed
// - bit 5 of pin config selects fast-mode-plus timings
// - bit 3 of pin config sets interrupt output polarity
// - bit 2 of pin config selects push-pull or open-drain outputs
// - hysteresis code maps 100 mV plus 50 mV per step
// - threshold code maps 2.5 V plus 50 mV per step
// - clock invert bits 6, 4, 3 of buck clock config
// - bit 2 of buck clock config enables active rail discharge
// - bit 5 of reset config forces reset output asserted always
// - bit 2 of reset config skips system enable load in second fuse read
// - bit 1 of reset config allows interrupts in power-down state
// - converter auto bits enable and select first setting at power-up
// - regulator auto bits 3..0 enable and select first setting at power-up
// - bits 6 and 5 of phase config select full-current mode
// - bit 3 of phase config merges converters one and two dual phase
`ifndef PMCRB_MAP_SVH
`define PMCRB_MAP_SVH
`define PMCRB_OFS_LDO4B    9'h0bd
`define PMCRB_OFS_BBAT     9'h0c5
`define PMCRB_OFS_IFADDR   9'h105
`define PMCRB_OFS_CFGA     9'h106
`define PMCRB_OFS_CFGB     9'h107
`define PMCRB_OFS_CFGC     9'h108
`define PMCRB_OFS_CFGD     9'h109
`define PMCRB_OFS_CFGE     9'h10a
`define PMCRB_OFS_CFGG     9'h10c
`define PMCRB_OFS_CFGH     9'h10d
`define PMCRB_RST_ZERO     8'h00
`define PMCRB_MASK_CFGA    8'h7f
`define PMCRB_MASK_IFADDR  8'hf0
`define PMCRB_VMIN_CODE    6'h02
`define PMCRB_VMAX_CODE    6'h38
`define PMCRB_RST_BASE     4'h5
`endif

// [common/pmcrb_pkg.sv]
// types shared by the configuration register bank
package pmcrb_pkg;
  typedef logic [7:0] pmcrb_byte_t;
  typedef logic [8:0] pmcrb_addr_t;
endpackage

// [hdl/pmcrb_bank.sv]
// configuration register bank: stores settings and drives decoded controls
// assumes the serial front end delivers one-cycle write strobes and read requests
`timescale 1ns/1ps
`include "pmcrb_map.svh"
module pmcrb_bank
  import pmcrb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire pmcrb_addr_t addr_i,
  input  wire pmcrb_byte_t wdata_i,
  input  wire logic [6:0]  dev_addr_i,
  input  wire logic        application_fuse_lock_i,
  input  wire logic        reg4_second_selected_i,
  input  wire logic        power_down_state_i,
  input  wire logic        irq_event_i,
  input  wire logic        reset_req_i,
  output pmcrb_byte_t      rdata_o,
  output logic             rvalid_o,
  output logic             addr_match_o,
  output logic [5:0]       reg4_second_voltage_o,
  output logic             reg4_sleep_o,
  output logic [3:0]       backup_charge_current_o,
  output logic [3:0]       backup_charge_termination_o,
  output logic             permanent_high_speed_o,
  output logic             fast_plus_timing_select_o,
  output logic             interrupt_request_out_o,
  output logic             interrupt_request_oe_o,
  output logic             system_reset_out_o,
  output logic             system_reset_oe_o,
  output logic [2:0]       supply_fault_hysteresis_o,
  output logic [3:0]       supply_fault_threshold_o,
  output logic [2:0]       clock_invert_o,
  output logic             rail_active_discharge_o,
  output logic             skip_sysen_fuse_load_o,
  output logic [3:0]       conv_powerup_enable_o,
  output logic [3:0]       reg_powerup_enable_o,
  output logic [1:0]       full_current_o,
  output logic             dual_phase_select_o
);
  pmcrb_byte_t ldo4b_r, bbat_r, ifaddr_r, cfga_r, cfgb_r, cfgc_r, cfgd_r, cfge_r, cfgg_r, cfgh_r;
  pmcrb_byte_t rd_nxt;
  logic        irq_act, rst_act, irq_lvl, rst_lvl;

  function automatic logic [5:0] clamp_code(input logic [5:0] c);
    if (c < `PMCRB_VMIN_CODE) return `PMCRB_VMIN_CODE;
    if (c > `PMCRB_VMAX_CODE) return `PMCRB_VMAX_CODE;
    return c;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ldo4b_r  <= `PMCRB_RST_ZERO;
      bbat_r   <= `PMCRB_RST_ZERO;
      ifaddr_r <= {`PMCRB_RST_BASE, 4'h0};
      cfga_r   <= `PMCRB_RST_ZERO;
      cfgb_r   <= `PMCRB_RST_ZERO;
      cfgc_r   <= `PMCRB_RST_ZERO;
      cfgd_r   <= `PMCRB_RST_ZERO;
      cfge_r   <= `PMCRB_RST_ZERO;
      cfgg_r   <= `PMCRB_RST_ZERO;
      cfgh_r   <= `PMCRB_RST_ZERO;
    end else if (wr_i) begin
      unique case (addr_i)
        `PMCRB_OFS_LDO4B:  ldo4b_r <= wdata_i;
        `PMCRB_OFS_BBAT:   bbat_r  <= wdata_i;
        `PMCRB_OFS_IFADDR: if (!application_fuse_lock_i) ifaddr_r <= wdata_i & `PMCRB_MASK_IFADDR;
        `PMCRB_OFS_CFGA:   cfga_r  <= wdata_i & `PMCRB_MASK_CFGA;
        `PMCRB_OFS_CFGB:   cfgb_r  <= wdata_i;
        `PMCRB_OFS_CFGC:   cfgc_r  <= wdata_i;
        `PMCRB_OFS_CFGD:   cfgd_r  <= wdata_i;
        `PMCRB_OFS_CFGE:   cfge_r  <= wdata_i;
        `PMCRB_OFS_CFGG:   cfgg_r  <= wdata_i;
        `PMCRB_OFS_CFGH:   cfgh_r  <= wdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (addr_i)
      `PMCRB_OFS_LDO4B:  rd_nxt = ldo4b_r;
      `PMCRB_OFS_BBAT:   rd_nxt = bbat_r;
      `PMCRB_OFS_IFADDR: rd_nxt = ifaddr_r;
      `PMCRB_OFS_CFGA:   rd_nxt = cfga_r;
      `PMCRB_OFS_CFGB:   rd_nxt = cfgb_r;
      `PMCRB_OFS_CFGC:   rd_nxt = cfgc_r;
      `PMCRB_OFS_CFGD:   rd_nxt = cfgd_r;
      `PMCRB_OFS_CFGE:   rd_nxt = cfge_r;
      `PMCRB_OFS_CFGG:   rd_nxt = cfgg_r;
      `PMCRB_OFS_CFGH:   rd_nxt = cfgh_r;
      default:           rd_nxt = `PMCRB_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= `PMCRB_RST_ZERO;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) rdata_o <= rd_nxt;
    end
  end

  // interrupt is suppressed in power-down unless enabled
  assign irq_act = irq_event_i && (!power_down_state_i || cfgd_r[1]);
  assign rst_act = reset_req_i || cfgd_r[5];
  assign irq_lvl = cfga_r[3] ? irq_act : !irq_act;
  assign rst_lvl = !rst_act;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_match_o                <= 1'b0;
      reg4_second_voltage_o       <= `PMCRB_VMIN_CODE;
      reg4_sleep_o                <= 1'b0;
      backup_charge_current_o     <= 4'h0;
      backup_charge_termination_o <= 4'h0;
      permanent_high_speed_o      <= 1'b0;
      fast_plus_timing_select_o   <= 1'b0;
      interrupt_request_out_o     <= 1'b1;
      interrupt_request_oe_o      <= 1'b1;
      system_reset_out_o          <= 1'b0;
      system_reset_oe_o           <= 1'b1;
      supply_fault_hysteresis_o   <= 3'h0;
      supply_fault_threshold_o    <= 4'h0;
      clock_invert_o              <= 3'h0;
      rail_active_discharge_o     <= 1'b0;
      skip_sysen_fuse_load_o      <= 1'b0;
      conv_powerup_enable_o       <= 4'h0;
      reg_powerup_enable_o        <= 4'h0;
      full_current_o              <= 2'h0;
      dual_phase_select_o         <= 1'b0;
    end else begin
      // low bit of dev address ignored so base*8 and base*8+1 both match
      addr_match_o                <= (dev_addr_i[6:1] == {ifaddr_r[7:4], 2'b00});
      reg4_second_voltage_o       <= clamp_code(ldo4b_r[5:0]);
      reg4_sleep_o                <= ldo4b_r[7] && reg4_second_selected_i;
      backup_charge_current_o     <= bbat_r[7:4];
      backup_charge_termination_o <= bbat_r[3:0];
      permanent_high_speed_o      <= cfga_r[6];
      fast_plus_timing_select_o   <= cfga_r[5];
      // open-drain drives only the low level; released high needs pull-up
      interrupt_request_out_o     <= irq_lvl;
      interrupt_request_oe_o      <= !cfga_r[2] || !irq_lvl;
      system_reset_out_o          <= rst_lvl;
      system_reset_oe_o           <= !cfga_r[2] || !rst_lvl;
      supply_fault_hysteresis_o   <= cfgb_r[6:4];
      supply_fault_threshold_o    <= cfgb_r[3:0];
      clock_invert_o              <= {cfgc_r[6], cfgc_r[4], cfgc_r[3]};
      rail_active_discharge_o     <= cfgc_r[2];
      skip_sysen_fuse_load_o      <= cfgd_r[2];
      conv_powerup_enable_o       <= {cfge_r[2], cfge_r[4], cfge_r[1], cfge_r[0]};
      reg_powerup_enable_o        <= cfgg_r[3:0];
      full_current_o              <= {cfgh_r[5], cfgh_r[6]};
      dual_phase_select_o         <= cfgh_r[3];
    end
  end

  lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    application_fuse_lock_i && wr_i |=> $stable(ifaddr_r)) else $error("address base changed while locked");
  force_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfgd_r[5] |=> !system_reset_out_o) else $error("forced reset not asserted");
  clamp_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ldo4b_r[5:0] < 6'h02 |=> reg4_second_voltage_o == 6'h02) else $error("low code not clamped");
  clamp_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ldo4b_r[5:0] > 6'h38 |=> reg4_second_voltage_o == 6'h38) else $error("high code not clamped");
  sleep_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ldo4b_r[7] && reg4_second_selected_i |=> reg4_sleep_o) else $error("sleep not forced");
  addr_plus_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dev_addr_i == {ifaddr_r[7:4], 3'b001} |=> addr_match_o) else $error("plus one address missed");
  addr_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dev_addr_i == {ifaddr_r[7:4], 3'b000} |=> addr_match_o) else $error("base address missed");
  od_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfga_r[2] ##1 interrupt_request_out_o |-> !interrupt_request_oe_o) else $error("open-drain drives high");
  pd_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_down_state_i && !cfgd_r[1] |=> interrupt_request_out_o == !cfga_r[3] || $changed(cfga_r)) else $error("irq in power-down");
  irq_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_act |=> interrupt_request_out_o == cfga_r[3] || $changed(cfga_r)) else $error("irq polarity wrong");
  reset_request_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_req_i |=> !system_reset_out_o) else $error("requested reset not asserted");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 cfga_r[7] == 1'b0 && ifaddr_r[3:0] == 4'h0) else $error("reserved read-only bit set");
endmodule // pmcrb_bank

// [sim/pmcrb_host_model.sv]
// host model: issues single-byte register writes and reads to the bank
// assumes the bank takes a request on the rising edge where wr_i or rd_i is high
`timescale 1ns/1ps
module pmcrb_host_model
  import pmcrb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire pmcrb_byte_t rdata_i,
  input  wire logic        rvalid_i,
  output logic             wr_o,
  output logic             rd_o,
  output pmcrb_addr_t      addr_o,
  output pmcrb_byte_t      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end
  task automatic wr_reg(input pmcrb_addr_t a, input pmcrb_byte_t d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // released lines carry inverted data so a stale value never looks valid
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd_reg(input pmcrb_addr_t a, output pmcrb_byte_t d);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rvalid_i ? rdata_i : 8'hxx;
  endtask
endmodule // pmcrb_host_model

// [sim/test_pmcrb_bank.sv]
// testbench: register access, decoded controls, lock, pin drivers
// assumes the host model drives the register port of the bank
`timescale 1ns/1ps
`include "pmcrb_map.svh"
module test_pmcrb_bank;
  import pmcrb_pkg::*;
  logic clk, rst, lock, sel, pdown, irq_ev, rreq, wr, rd, rv, am, sleep, hsm, fmp, irq, irq_oe, rso, rso_oe, dis, skip, dual;
  logic [6:0] dev;
  pmcrb_addr_t addr;
  pmcrb_byte_t wd, rdat, d;
  logic [5:0] v4;
  logic [3:0] cur, term, thr, conv, ldo;
  logic [2:0] hyst, inv;
  logic [1:0] fc;
  int num_errors = 0;
  int comparisons = 0;
  pmcrb_addr_t ofs[10] = '{9'h0bd, 9'h0c5, 9'h105, 9'h106, 9'h107, 9'h108, 9'h109, 9'h10a, 9'h10c, 9'h10d};
  pmcrb_byte_t msk[10] = '{8'hff, 8'hff, 8'hf0, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  pmcrb_byte_t pat[10] = '{8'h80, 8'h5c, 8'h30, 8'h40, 8'h3a, 8'h48, 8'h04, 8'h15, 8'h05, 8'h48};
  wire logic [39:0] dec = {sleep, v4, cur, term, hsm, fmp, hyst, thr, inv, dis, skip, conv, ldo, fc, dual};
  pmcrb_host_model pmcrb_host_model_i (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wd));
  pmcrb_bank pmcrb_bank_i (.clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wd),
    .dev_addr_i(dev), .application_fuse_lock_i(lock), .reg4_second_selected_i(sel), .power_down_state_i(pdown),
    .irq_event_i(irq_ev), .reset_req_i(rreq), .rdata_o(rdat), .rvalid_o(rv), .addr_match_o(am),
    .reg4_second_voltage_o(v4), .reg4_sleep_o(sleep), .backup_charge_current_o(cur),
    .backup_charge_termination_o(term), .permanent_high_speed_o(hsm), .fast_plus_timing_select_o(fmp),
    .interrupt_request_out_o(irq), .interrupt_request_oe_o(irq_oe), .system_reset_out_o(rso),
    .system_reset_oe_o(rso_oe), .supply_fault_hysteresis_o(hyst), .supply_fault_threshold_o(thr),
    .clock_invert_o(inv), .rail_active_discharge_o(dis), .skip_sysen_fuse_load_o(skip),
    .conv_powerup_enable_o(conv), .reg_powerup_enable_o(ldo), .full_current_o(fc), .dual_phase_select_o(dual));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input pmcrb_addr_t a, input pmcrb_byte_t exp);
    pmcrb_host_model_i.rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic settle;
    // decoded outputs trail a write by two edges
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end
  initial begin
    {rst, lock, sel, pdown, irq_ev, rreq, dev} = {1'b1, 12'h000};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(v4, 6'h02);
    rchk(`PMCRB_OFS_IFADDR, 8'h50);
    rchk(`PMCRB_OFS_CFGA, 8'h00);
    $display("reset test done");
    sel <= 1'b1;
    foreach (ofs[i]) pmcrb_host_model_i.wr_reg(ofs[i], 8'hff);
    pmcrb_host_model_i.wr_reg(9'h10b, 8'hff);
    foreach (ofs[i]) rchk(ofs[i], msk[i]);
    rchk(9'h10b, 8'h00);
    chk(dec, {1'b1, 6'h38, {33{1'b1}}});
    $display("all-ones test done");
    lock <= 1'b1;
    foreach (ofs[i]) pmcrb_host_model_i.wr_reg(ofs[i], pat[i]);
    foreach (ofs[i]) rchk(ofs[i], (i == 2) ? 8'hf0 : pat[i]);
    settle();
    chk(dec, {1'b1, 6'h02, 4'h5, 4'hc, 2'b10, 3'h3, 4'ha, 3'b101, 2'b01, 4'b1101, 4'b0101, 2'b01, 1'b1});
    sel <= 1'b0;
    lock <= 1'b0;
    pmcrb_host_model_i.wr_reg(`PMCRB_OFS_IFADDR, 8'h30);
    rchk(`PMCRB_OFS_IFADDR, 8'h30);
    chk(sleep, 1'b0);
    foreach (pat[i]) if (i < 3) begin
      dev <= 7'h18 + 7'(i);
      settle();
      chk(am, i < 2);
    end
    $display("lock and address test done");
    irq_ev <= 1'b1;
    settle();
    chk({irq, irq_oe}, 2'b01);
    pmcrb_host_model_i.wr_reg(`PMCRB_OFS_CFGA, 8'h4c);
    pmcrb_host_model_i.wr_reg(`PMCRB_OFS_CFGD, 8'h24);
    settle();
    chk(irq_oe, 1'b0);
    chk({rso, rso_oe}, 2'b01);
    irq_ev <= 1'b0;
    settle();
    chk({irq, irq_oe}, 2'b01);
    pdown  <= 1'b1;
    irq_ev <= 1'b1;
    settle();
    chk(irq, 1'b0);
    pmcrb_host_model_i.wr_reg(`PMCRB_OFS_CFGD, 8'h02);
    settle();
    chk({irq, irq_oe, rso, rso_oe}, 4'b1010);
    rreq <= 1'b1;
    settle();
    chk({rso, rso_oe}, 2'b01);
    $display("pin driver test done");
    end_sim();
  end
endmodule // test_pmcrb_bank
